// ---- common/gpx_defs.svh ----
// offsets, reset values and field layout of the port c to f block
// How it works
// - direction bit 1 makes the pin an input, 0 drives it from the latch
// - reading a port returns pin levels, with analog port f pins read as zero; writing updates only the latch
// - in bus mode port d carries bus bits 15 to 8
// - microprocessor or extended modes give c, d to the bus; others keep gpio
// - port e has four bits; bits 7 to 4 have no storage
// - bus mode: e0 address latch, e1 output enable, e2 write strobe
// - output enable and write strobes are active low
// - bus mode takes only e2 to e0; e3 stays gpio or capture input
// - non-bus modes run e2 to e0 as ordinary gpio
// - all eight port f pins double as converter inputs
// - every reset makes port f analog until software reconfigures it
// - c, d, e direction registers reset to all ones on every reset
// - c, d, e latches undefined at power-on, kept across soft resets
// - unimplemented bits read as zero
// - c, d, e decode in bank 1, f in bank 5
// - in bus mode port c carries bus bits 7 to 0
`ifndef GPX_DEFS_SVH
`define GPX_DEFS_SVH

// -----------------------------------------------------------------
// banks and offsets
// -----------------------------------------------------------------
`define GPX_BANK_PORTS 4'h1
`define GPX_BANK_ANALOG 4'h5
`define GPX_BANK_CAPTURE 4'h7
`define GPX_OFF_C_DIR 8'h10
`define GPX_OFF_C_PINS 8'h11
`define GPX_OFF_D_DIR 8'h12
`define GPX_OFF_D_PINS 8'h13
`define GPX_OFF_E_DIR 8'h14
`define GPX_OFF_E_PINS 8'h15
`define GPX_OFF_F_DIR 8'h10
`define GPX_OFF_F_PINS 8'h11
`define GPX_OFF_CONV_CFG 8'h15
`define GPX_OFF_CAPTURE_INPUT_FOUR_LOW 8'h14
`define GPX_OFF_CAPTURE_INPUT_FOUR_HIGH 8'h15
`define GPX_OFF_CAP_CTRL 8'h16

// -----------------------------------------------------------------
// reset values and masks
// -----------------------------------------------------------------
`define GPX_DIR_RESET 8'hff
`define GPX_E_DIR_RESET 4'hf
`define GPX_LATCH_POR 8'h00
`define GPX_F_LATCH_RESET 8'h00
`define GPX_CONV_RESET 8'h00
`define GPX_CONV_MASK 8'hef
`define GPX_CONV_DIGITAL 4'he
`define GPX_CTRL_RESET 5'h00

`endif

// ---- common/gpx_pkg.sv ----
// types shared by the port c to f block
package gpx_pkg;

    // processor mode from the configuration bits
    typedef enum logic [1:0] {
        GPX_MODE_MICROPROC = 2'h0,
        GPX_MODE_EXTENDED = 2'h1,
        GPX_MODE_MICROCTRL = 2'h2,
        GPX_MODE_PROTECTED = 2'h3
    } gpx_mode_t;

endpackage : gpx_pkg

// ---- core/gpx_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps

module gpx_sync #(
    parameter int WIDTH = 28
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb
    begin
        next_stage1 = reset_n ? async_in : '0;
        next_sync_out = reset_n ? stage1 : '0;
    end

    always_ff @(posedge mclk)
    begin
        stage1 <= next_stage1;
        sync_out <= next_sync_out;
    end

endmodule : gpx_sync

// ---- core/gpx_ports.sv ----
// general purpose ports c to f with system bus and converter sharing
`timescale 1ns/1ps
`include "gpx_defs.svh"

module gpx_ports (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic soft_reset_n,
    input wire gpx_pkg::gpx_mode_t proc_mode,
    input wire logic [3:0] bank_select,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] pad_c_in,
    output logic [7:0] pad_c_out,
    output logic [7:0] pad_c_oe,
    input wire logic [7:0] pad_d_in,
    output logic [7:0] pad_d_out,
    output logic [7:0] pad_d_oe,
    input wire logic [3:0] pad_e_in,
    output logic [3:0] pad_e_out,
    output logic [3:0] pad_e_oe,
    input wire logic [7:0] pad_f_in,
    output logic [7:0] pad_f_out,
    output logic [7:0] pad_f_oe,
    input wire logic [15:0] bus_out_word,
    input wire logic bus_drive,
    input wire logic bus_latch_strobe,
    input wire logic bus_read_strobe_n,
    input wire logic bus_write_strobe_n,
    output logic [15:0] bus_in_word,
    output logic system_bus_active,
    output logic capture_input_four,
    input wire logic [15:0] capture4_value,
    input wire logic [1:0] capture_overflow,
    output logic [4:0] capture_pwm3_control,
    output logic [7:0] converter_pin_config,
    output logic [7:0] port_f_analog
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [7:0] port_c_direction;
    logic [7:0] port_c_pins;
    logic [7:0] port_d_direction;
    logic [7:0] port_d_pins;
    logic [3:0] port_e_direction;
    logic [3:0] port_e_pins;
    logic [7:0] port_f_direction;
    logic [7:0] port_f_pins;
    logic [7:0] next_port_c_direction;
    logic [7:0] next_port_c_pins;
    logic [7:0] next_port_d_direction;
    logic [7:0] next_port_d_pins;
    logic [3:0] next_port_e_direction;
    logic [3:0] next_port_e_pins;
    logic [7:0] next_port_f_direction;
    logic [7:0] next_port_f_pins;
    logic [7:0] next_converter_pin_config;
    logic [4:0] next_capture_pwm3_control;
    logic [7:0] next_reg_rdata;
    logic [7:0] next_pad_c_out;
    logic [7:0] next_pad_c_oe;
    logic [7:0] next_pad_d_out;
    logic [7:0] next_pad_d_oe;
    logic [3:0] next_pad_e_out;
    logic [3:0] next_pad_e_oe;
    logic [7:0] next_pad_f_out;
    logic [7:0] next_pad_f_oe;
    logic [7:0] next_port_f_analog;
    logic [27:0] pins_sync;
    logic [7:0] c_sync;
    logic [7:0] d_sync;
    logic [3:0] e_sync;
    logic [7:0] f_sync;
    logic any_reset;
    logic bus_mode;

    function automatic logic reg_hit(input logic [3:0] bank, input logic [7:0] addr,
                                     input logic [3:0] want_bank, input logic [7:0] want_addr);
        reg_hit = (bank == want_bank) && (addr == want_addr);
    endfunction : reg_hit

    // -----------------------------------------------------------------
    // pin synchronisation
    // -----------------------------------------------------------------
    gpx_sync #(
        .WIDTH(28)
    ) gpx_sync_i (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in({pad_f_in, pad_e_in, pad_d_in, pad_c_in}),
        .sync_out(pins_sync)
    );

    assign c_sync = pins_sync[7:0];
    assign d_sync = pins_sync[15:8];
    assign e_sync = pins_sync[19:16];
    assign f_sync = pins_sync[27:20];
    assign bus_in_word = {d_sync, c_sync};
    assign capture_input_four = e_sync[3];
    assign any_reset = !reset_n || !soft_reset_n;

    // only two of the four modes hand ports c and d and pins e2 to e0 to the bus
    assign bus_mode = (proc_mode == gpx_pkg::GPX_MODE_MICROPROC)
                      || (proc_mode == gpx_pkg::GPX_MODE_EXTENDED);
    assign system_bus_active = bus_mode;

    // -----------------------------------------------------------------
    // register writes and resets
    // -----------------------------------------------------------------
    always_comb
    begin
        next_port_c_direction = port_c_direction;
        next_port_c_pins = port_c_pins;
        next_port_d_direction = port_d_direction;
        next_port_d_pins = port_d_pins;
        next_port_e_direction = port_e_direction;
        next_port_e_pins = port_e_pins;
        next_port_f_direction = port_f_direction;
        next_port_f_pins = port_f_pins;
        next_converter_pin_config = converter_pin_config;
        next_capture_pwm3_control = capture_pwm3_control;
        if (reg_wr)
        begin
            // latches take writes even while the bus owns the pins
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_C_DIR))
                next_port_c_direction = reg_wdata;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_C_PINS))
                next_port_c_pins = reg_wdata;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_D_DIR))
                next_port_d_direction = reg_wdata;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_D_PINS))
                next_port_d_pins = reg_wdata;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_E_DIR))
                next_port_e_direction = reg_wdata[3:0];
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_E_PINS))
                next_port_e_pins = reg_wdata[3:0];
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_ANALOG, `GPX_OFF_F_DIR))
                next_port_f_direction = reg_wdata;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_ANALOG, `GPX_OFF_F_PINS))
                next_port_f_pins = reg_wdata;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_ANALOG, `GPX_OFF_CONV_CFG))
                next_converter_pin_config = reg_wdata & `GPX_CONV_MASK;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_CAPTURE, `GPX_OFF_CAP_CTRL))
                next_capture_pwm3_control = reg_wdata[4:0];
        end
        if (any_reset)
        begin
            next_port_c_direction = `GPX_DIR_RESET;
            next_port_d_direction = `GPX_DIR_RESET;
            next_port_e_direction = `GPX_E_DIR_RESET;
            next_port_f_direction = `GPX_DIR_RESET;
            next_port_f_pins = `GPX_F_LATCH_RESET;
            next_converter_pin_config = `GPX_CONV_RESET;
            next_capture_pwm3_control = `GPX_CTRL_RESET;
        end
        // power-on value is undefined; zero is one legal choice, soft reset keeps it
        if (!reset_n)
        begin
            next_port_c_pins = `GPX_LATCH_POR;
            next_port_d_pins = `GPX_LATCH_POR;
            next_port_e_pins = 4'(`GPX_LATCH_POR);
        end
    end

    always_ff @(posedge mclk)
    begin
        port_c_direction <= next_port_c_direction;
        port_c_pins <= next_port_c_pins;
        port_d_direction <= next_port_d_direction;
        port_d_pins <= next_port_d_pins;
        port_e_direction <= next_port_e_direction;
        port_e_pins <= next_port_e_pins;
        port_f_direction <= next_port_f_direction;
        port_f_pins <= next_port_f_pins;
        converter_pin_config <= next_converter_pin_config;
        capture_pwm3_control <= next_capture_pwm3_control;
    end

    // -----------------------------------------------------------------
    // read data
    // -----------------------------------------------------------------
    always_comb
    begin
        next_reg_rdata = reg_rdata;
        if (reg_rd)
        begin
            next_reg_rdata = 8'h00;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_C_DIR))
                next_reg_rdata = port_c_direction;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_C_PINS))
                next_reg_rdata = c_sync;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_D_DIR))
                next_reg_rdata = port_d_direction;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_D_PINS))
                next_reg_rdata = d_sync;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_E_DIR))
                next_reg_rdata = {4'h0, port_e_direction};
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_PORTS, `GPX_OFF_E_PINS))
                next_reg_rdata = {4'h0, e_sync};
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_ANALOG, `GPX_OFF_F_DIR))
                next_reg_rdata = port_f_direction;
            // analog pins have their digital buffer off and read low
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_ANALOG, `GPX_OFF_F_PINS))
                next_reg_rdata = f_sync & ~port_f_analog;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_ANALOG, `GPX_OFF_CONV_CFG))
                next_reg_rdata = converter_pin_config;
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_CAPTURE, `GPX_OFF_CAPTURE_INPUT_FOUR_LOW))
                next_reg_rdata = capture4_value[7:0];
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_CAPTURE, `GPX_OFF_CAPTURE_INPUT_FOUR_HIGH))
                next_reg_rdata = capture4_value[15:8];
            if (reg_hit(bank_select, reg_addr, `GPX_BANK_CAPTURE, `GPX_OFF_CAP_CTRL))
                next_reg_rdata = {1'b0, capture_overflow, capture_pwm3_control};
        end
        if (any_reset)
            next_reg_rdata = 8'h00;
    end

    always_ff @(posedge mclk)
    begin
        reg_rdata <= next_reg_rdata;
    end

    // -----------------------------------------------------------------
    // pin drivers
    // -----------------------------------------------------------------
    always_comb
    begin
        next_pad_c_out = port_c_pins;
        next_pad_c_oe = ~port_c_direction;
        next_pad_d_out = port_d_pins;
        next_pad_d_oe = ~port_d_direction;
        next_pad_e_out = port_e_pins;
        next_pad_e_oe = ~port_e_direction;
        if (bus_mode)
        begin
            next_pad_c_out = bus_out_word[7:0];
            next_pad_c_oe = {8{bus_drive}};
            next_pad_d_out = bus_out_word[15:8];
            next_pad_d_oe = {8{bus_drive}};
            // read and write strobes arrive already active low, the latch strobe active high; e3 is left to its registers
            next_pad_e_out[2:0] = {bus_write_strobe_n, bus_read_strobe_n, bus_latch_strobe};
            next_pad_e_oe[2:0] = 3'h7;
        end
        next_port_f_analog = (converter_pin_config[3:0] == `GPX_CONV_DIGITAL) ? 8'h00 : 8'hff;
        next_pad_f_out = port_f_pins;
        next_pad_f_oe = ~port_f_direction & ~port_f_analog;
        if (any_reset)
        begin
            next_pad_c_out = 8'h00;
            next_pad_c_oe = 8'h00;
            next_pad_d_out = 8'h00;
            next_pad_d_oe = 8'h00;
            next_pad_e_out = 4'h0;
            next_pad_e_oe = 4'h0;
            next_pad_f_out = 8'h00;
            next_pad_f_oe = 8'h00;
            next_port_f_analog = 8'hff;
        end
    end

    always_ff @(posedge mclk)
    begin
        pad_c_out <= next_pad_c_out;
        pad_c_oe <= next_pad_c_oe;
        pad_d_out <= next_pad_d_out;
        pad_d_oe <= next_pad_d_oe;
        pad_e_out <= next_pad_e_out;
        pad_e_oe <= next_pad_e_oe;
        pad_f_out <= next_pad_f_out;
        pad_f_oe <= next_pad_f_oe;
        port_f_analog <= next_port_f_analog;
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (any_reset);

    AST_DIR_RESET: assert property ($past(any_reset) |-> port_c_direction == 8'hff
        && port_d_direction == 8'hff && port_e_direction == 4'hf)
        else $error("direction registers not all inputs after reset");

    AST_GPIO_DRIVE: assert property (!$past(bus_mode) && !$past(any_reset)
        |-> pad_c_oe == ~$past(port_c_direction) && pad_d_out == $past(port_d_pins))
        else $error("gpio pin drive does not follow direction and latch");

    AST_READ_PINS: assert property (reg_rd
        && reg_hit(bank_select, reg_addr, 4'h1, 8'h13) ##1 !any_reset |-> reg_rdata == $past(d_sync))
        else $error("port d read did not return pin levels");

    AST_WRITE_LATCH: assert property (reg_wr && !bus_mode
        && reg_hit(bank_select, reg_addr, 4'h1, 8'h11) ##1 !bus_mode [*1] ##1 !bus_mode
        |-> pad_c_out == $past(reg_wdata, 2))
        else $error("port c latch write did not reach the pins in two cycles");

    AST_BUS_UPPER: assert property ($past(bus_mode) && !$past(any_reset)
        |-> pad_d_out == $past(bus_out_word[15:8]) && pad_d_oe == {8{$past(bus_drive)}})
        else $error("port d does not carry the upper bus byte");

    AST_BUS_LOWER: assert property ($past(bus_mode) && !$past(any_reset)
        |-> pad_c_out == $past(bus_out_word[7:0]) && pad_c_oe == {8{$past(bus_drive)}})
        else $error("port c does not carry the lower bus byte");

    AST_BUS_MODE: assert property (system_bus_active == (proc_mode inside
        {gpx_pkg::GPX_MODE_MICROPROC, gpx_pkg::GPX_MODE_EXTENDED}))
        else $error("bus ownership does not match processor mode");

    AST_E_HIGH_ZERO: assert property (reg_rd && bank_select == 4'h1
        && reg_addr inside {8'h14, 8'h15} ##1 !any_reset |-> reg_rdata[7:4] == 4'h0)
        else $error("port e upper bits read nonzero");

    AST_STROBES: assert property ($past(bus_mode) && !$past(any_reset)
        |-> pad_e_oe[2:0] == 3'h7 && pad_e_out[1] == $past(bus_read_strobe_n)
        && pad_e_out[2] == $past(bus_write_strobe_n) && pad_e_out[0] == $past(bus_latch_strobe))
        else $error("port e strobes not driven from the bus");

    AST_E3_GPIO: assert property (!$past(any_reset)
        |-> pad_e_oe[3] == ~$past(port_e_direction[3]) && pad_e_out[3] == $past(port_e_pins[3]))
        else $error("port e bit 3 not under its own registers");

    AST_F_ANALOG: assert property ($past(any_reset) ##1 converter_pin_config[3:0] != 4'he
        |-> port_f_analog == 8'hff && pad_f_oe == 8'h00)
        else $error("port f not analog after reset");

    AST_LATCH_KEEP: assert property (@(posedge mclk) disable iff (!reset_n)
        !soft_reset_n |=> port_d_pins == $past(port_d_pins))
        else $error("soft reset disturbed a data latch");

    AST_BANK_MISS: assert property (reg_wr && bank_select != 4'h1 && !(bank_select == 4'h5
        && reg_addr == 8'h11) |=> port_c_pins == $past(port_c_pins) && port_e_pins == $past(port_e_pins))
        else $error("write outside bank 1 changed a port latch");

    COV_BUS_CYCLE: cover property (bus_mode && bus_drive ##1 !bus_latch_strobe ##1 !bus_write_strobe_n);
    COV_GPIO_WRITE: cover property (!bus_mode && reg_wr && reg_hit(bank_select, reg_addr, 4'h1, 8'h13));
    COV_F_DIGITAL: cover property (port_f_analog == 8'h00 && pad_f_oe != 8'h00);
    COV_SOFT_RESET: cover property (@(posedge mclk) disable iff (!reset_n) reset_n && !soft_reset_n);

endmodule : gpx_ports

// ---- bench/gpx_pin_world.sv ----
// board-side model of the pins: external levels on ports c to f
`timescale 1ns/1ps

module gpx_pin_world (
    input wire logic [7:0] pad_c_out,
    input wire logic [7:0] pad_c_oe,
    input wire logic [7:0] pad_d_out,
    input wire logic [7:0] pad_d_oe,
    input wire logic [3:0] pad_e_out,
    input wire logic [3:0] pad_e_oe,
    input wire logic [7:0] pad_f_out,
    input wire logic [7:0] pad_f_oe,
    input wire logic [7:0] ext_c,
    input wire logic [7:0] ext_d,
    input wire logic [3:0] ext_e,
    input wire logic [7:0] ext_f,
    output logic [7:0] pad_c_in,
    output logic [7:0] pad_d_in,
    output logic [3:0] pad_e_in,
    output logic [7:0] pad_f_in
);
    // each wire carries the device level where it drives, the board level elsewhere
    assign pad_c_in = (pad_c_oe & pad_c_out) | (~pad_c_oe & ext_c);
    assign pad_d_in = (pad_d_oe & pad_d_out) | (~pad_d_oe & ext_d);
    assign pad_e_in = (pad_e_oe & pad_e_out) | (~pad_e_oe & ext_e);
    assign pad_f_in = (pad_f_oe & pad_f_out) | (~pad_f_oe & ext_f);
endmodule : gpx_pin_world

// ---- bench/gpx_ports_tb.sv ----
// self-checking bench for the port c to f block
`timescale 1ns/1ps

module gpx_ports_tb;
    logic mclk = 1'b0, reset_n = 1'b0, soft_reset_n = 1'b1;
    gpx_pkg::gpx_mode_t proc_mode = gpx_pkg::GPX_MODE_MICROCTRL;
    logic [3:0] bank_select = 4'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] pad_c_in, pad_c_out, pad_c_oe, pad_d_in, pad_d_out, pad_d_oe;
    logic [7:0] pad_f_in, pad_f_out, pad_f_oe, converter_pin_config, port_f_analog;
    logic [3:0] pad_e_in, pad_e_out, pad_e_oe;
    logic [15:0] bus_out_word = 16'h0000, bus_in_word;
    logic bus_drive = 1'b0, bus_latch_strobe = 1'b0, bus_read_strobe_n = 1'b1, bus_write_strobe_n = 1'b1;
    logic system_bus_active, capture_input_four;
    logic [4:0] capture_pwm3_control;
    logic [7:0] ext_c = 8'h3c, ext_d = 8'h00, ext_f = 8'h00;
    logic [3:0] ext_e = 4'h6;
    int err_total = 0, samples_checked = 0;
    logic [19:0] tbl [9] = '{20'h110ff, 20'h112ff, 20'h1140f, 20'h510ff, 20'h51100,
                            20'h51500, 20'h714cd, 20'h715ab, 20'h21000};

    always #12.5 mclk = ~mclk;

    gpx_ports gpx_ports_i (.mclk(mclk), .reset_n(reset_n), .soft_reset_n(soft_reset_n),
        .proc_mode(proc_mode), .bank_select(bank_select), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pad_c_in(pad_c_in),
        .pad_c_out(pad_c_out), .pad_c_oe(pad_c_oe), .pad_d_in(pad_d_in), .pad_d_out(pad_d_out),
        .pad_d_oe(pad_d_oe), .pad_e_in(pad_e_in), .pad_e_out(pad_e_out), .pad_e_oe(pad_e_oe),
        .pad_f_in(pad_f_in), .pad_f_out(pad_f_out), .pad_f_oe(pad_f_oe), .bus_out_word(bus_out_word),
        .bus_drive(bus_drive), .bus_latch_strobe(bus_latch_strobe), .bus_read_strobe_n(bus_read_strobe_n),
        .bus_write_strobe_n(bus_write_strobe_n), .bus_in_word(bus_in_word),
        .system_bus_active(system_bus_active), .capture_input_four(capture_input_four),
        .capture4_value(16'habcd), .capture_overflow(2'b10), .capture_pwm3_control(capture_pwm3_control),
        .converter_pin_config(converter_pin_config), .port_f_analog(port_f_analog));

    gpx_pin_world gpx_pin_world_i (.pad_c_out(pad_c_out), .pad_c_oe(pad_c_oe), .pad_d_out(pad_d_out),
        .pad_d_oe(pad_d_oe), .pad_e_out(pad_e_out), .pad_e_oe(pad_e_oe), .pad_f_out(pad_f_out),
        .pad_f_oe(pad_f_oe), .ext_c(ext_c), .ext_d(ext_d), .ext_e(ext_e), .ext_f(ext_f),
        .pad_c_in(pad_c_in), .pad_d_in(pad_d_in), .pad_e_in(pad_e_in), .pad_f_in(pad_f_in));

    // -----------------------------------------------------------------
    // access tasks
    // -----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] bank, input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        bank_select <= bank;
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] bank, input logic [7:0] addr, input logic [7:0] exp);
        @(posedge mclk);
        bank_select <= bank;
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp}, "register read");
    endtask : rd

    // pads are registered and pin reads pass two sync flops, so wait well past both
    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask : settle

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        #(25 * 3000);
        err_total++;
        print_verdict();
    end

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd(tbl[i][19:16], tbl[i][15:8], tbl[i][7:0]);
        chk({8'h00, port_f_analog}, 16'h00ff, "f analog after reset");
        for (int m = 0; m < 4; m++)
        begin
            @(posedge mclk);
            proc_mode <= gpx_pkg::gpx_mode_t'(m[1:0]);
            #1;
            chk({15'h0, system_bus_active}, {15'h0, m < 2}, "bus mode decode");
        end
        @(posedge mclk);
        proc_mode <= gpx_pkg::GPX_MODE_MICROCTRL;
        // latch loaded before directions go to output
        wr(4'h1, 8'h11, 8'ha5);
        wr(4'h1, 8'h10, 8'h00);
        wr(4'h1, 8'h13, 8'h5a);
        wr(4'h1, 8'h12, 8'h0f);
        settle();
        chk({pad_c_oe, pad_c_out}, 16'hffa5, "port c drives latch");
        chk({pad_d_oe, pad_d_out}, 16'hf05a, "port d split direction");
        rd(4'h1, 8'h13, 8'h50);
        rd(4'h1, 8'h11, 8'ha5);
        wr(4'h1, 8'h10, 8'hff);
        settle();
        chk({8'h00, pad_c_oe}, 16'h0000, "port c released");
        rd(4'h1, 8'h11, 8'h3c);
        wr(4'h1, 8'h15, 8'hff);
        wr(4'h1, 8'h14, 8'hff);
        rd(4'h1, 8'h14, 8'h0f);
        settle();
        rd(4'h1, 8'h15, 8'h06);
        wr(4'h1, 8'h14, 8'h00);
        settle();
        chk({8'h00, pad_e_oe, pad_e_out}, 16'h00ff, "port e gpio outputs");
        @(posedge mclk);
        proc_mode <= gpx_pkg::GPX_MODE_MICROPROC;
        bus_out_word <= 16'h1234;
        bus_drive <= 1'b1;
        bus_latch_strobe <= 1'b1;
        bus_read_strobe_n <= 1'b0;
        settle();
        chk({pad_d_out, pad_c_out}, 16'h1234, "bus word on c and d");
        chk({pad_d_oe, pad_c_oe}, 16'hffff, "bus drives c and d");
        chk(bus_in_word, 16'h1234, "bus word seen on pins");
        chk({8'h00, pad_e_oe, pad_e_out}, 16'h00fd, "strobes on e");
        @(posedge mclk);
        proc_mode <= gpx_pkg::GPX_MODE_EXTENDED;
        bus_latch_strobe <= 1'b0;
        bus_read_strobe_n <= 1'b1;
        bus_write_strobe_n <= 1'b0;
        settle();
        chk({8'h00, pad_e_oe, pad_e_out}, 16'h00fa, "write strobe low");
        @(posedge mclk);
        proc_mode <= gpx_pkg::GPX_MODE_PROTECTED;
        settle();
        chk({pad_c_oe, pad_c_out}, 16'h00a5, "port c back to gpio");
        chk({8'h00, pad_e_oe, pad_e_out}, 16'h00ff, "port e back to gpio");
        wr(4'h5, 8'h11, 8'hc3);
        wr(4'h5, 8'h10, 8'h00);
        settle();
        chk({port_f_analog, pad_f_oe}, 16'hff00, "analog pins not driven");
        wr(4'h5, 8'h15, 8'h0e);
        settle();
        chk({pad_f_oe, pad_f_out}, 16'hffc3, "port f digital output");
        chk({port_f_analog, converter_pin_config}, 16'h000e, "converter config");
        rd(4'h5, 8'h15, 8'h0e);
        @(posedge mclk);
        soft_reset_n <= 1'b0;
        ext_e <= 4'h8;
        repeat (2) @(posedge mclk);
        soft_reset_n <= 1'b1;
        rd(4'h1, 8'h12, 8'hff);
        rd(4'h5, 8'h15, 8'h00);
        chk({8'h00, port_f_analog}, 16'h00ff, "f analog after soft reset");
        wr(4'h1, 8'h12, 8'h00);
        settle();
        chk({pad_d_oe, pad_d_out}, 16'hff5a, "latch kept over soft reset");
        chk({15'h0, capture_input_four}, 16'h0001, "e3 feeds capture");
        wr(4'h7, 8'h16, 8'hff);
        rd(4'h7, 8'h16, 8'h5f);
        chk({11'h0, capture_pwm3_control}, 16'h001f, "capture control bits");
        print_verdict();
    end
endmodule : gpx_ports_tb
